// File: dv/input_mux_out01_cfg_props.sv
/*
  Port checker for the input-mux and output-pair-0/1 bank.
  Assumes the ports of the bank module and a single mclk domain.
*/
`timescale 1ns/1ps
module input_mux_out01_cfg_props
  import clkgen_cfg_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              serial_mode,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [REG_W-1:0]  reg_wdata,
  input wire logic              ref_sel_pin,
  input wire logic [REG_W-1:0]  reg_rdata,
  input wire logic              reg_rvalid,
  input wire logic              reg_unmapped,
  input wire input_ctrl_t       input_ctrl,
  input wire out01_ctrl_t       out01_ctrl,
  input wire logic              auto_inputs_ready
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // accepted accesses, index hits and writes; the decode lands one edge after the store
  logic acc, hit, w4, w5, w6;
  assign acc = serial_mode && (reg_wr || reg_rd);
  assign hit = reg_addr inside {[16'h0004:16'h0006]};
  assign w4  = reg_wr && serial_mode && (reg_addr == INPUT_SELECT_CONFIG_IDX);
  assign w5  = reg_wr && serial_mode && (reg_addr == OUTPUT_PAIR0_CONTROL_IDX);
  assign w6  = reg_wr && serial_mode && (reg_addr == OUTPUT_PAIR0_DIVIDER_IDX);

  chk_shape_mode:
    assert property (w4 |=> ##1 {input_ctrl.reshape_on, input_ctrl.delay_on,
      input_ctrl.manual_mode} == $past(reg_wdata[15:13], 2)) else $error("shape or mode");
  chk_pri_div:
    assert property (w4 |=> ##1 input_ctrl.primary_divide_ratio
      == {1'b0, $past(reg_wdata[11:8], 2)} + 5'h01) else $error("primary divider");
  chk_out_state:
    assert property (w5 |=> ##1 {out01_ctrl.out1.output_state, out01_ctrl.out0.output_state,
      out01_ctrl.rail_level} == {$past(reg_wdata[6:5], 2), $past(reg_wdata[2:0], 2)})
      else $error("output state");
  chk_out_div:
    assert property (w6 |=> ##1 out01_ctrl.divide_ratio
      == {1'b0, $past(reg_wdata[7:0], 2)} + 9'h001) else $error("output divider");
  chk_pin_gate:
    assert property (input_ctrl.use_secondary |-> input_ctrl.manual_mode && $past(ref_sel_pin))
      else $error("secondary chosen");
  chk_auto_ready:
    assert property (auto_inputs_ready == (!input_ctrl.manual_mode
      && input_ctrl.primary_input_on && input_ctrl.secondary_input_on)) else $error("ready");
  chk_bank_locked:
    assert property (!serial_mode |=> !reg_rvalid && !reg_unmapped) else $error("locked");
  chk_read_valid:
    assert property (reg_rd && serial_mode |=> reg_rvalid) else $error("no rvalid");
  chk_unmapped_flag:
    assert property (acc && !hit |=> reg_unmapped) else $error("no unmapped");
endmodule

bind input_mux_out01_cfg input_mux_out01_cfg_props u_props (
  .mclk(mclk), .rst_n(rst_n), .serial_mode(serial_mode), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .ref_sel_pin(ref_sel_pin),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_unmapped(reg_unmapped),
  .input_ctrl(input_ctrl), .out01_ctrl(out01_ctrl), .auto_inputs_ready(auto_inputs_ready));

// File: dv/input_mux_out01_cfg_tb.sv
/*
  Self-checking bench for the input-mux and output-pair-0/1 bank.
  Assumes the package and the bank module are compiled first.
*/
`timescale 1ns/1ps
module input_mux_out01_cfg_tb;
  import clkgen_cfg_pkg::*;
  logic        mclk, rst_n, serial_mode, reg_wr, reg_rd, ref_sel_pin;
  logic        reg_rvalid, reg_unmapped, auto_inputs_ready;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, last, a;
  logic [15:0] m [4:6];
  input_ctrl_t input_ctrl;
  out01_ctrl_t out01_ctrl;
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;
  integer      seed = 7;

  input_mux_out01_cfg u_dut (
    .mclk(mclk), .rst_n(rst_n), .serial_mode(serial_mode), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .ref_sel_pin(ref_sel_pin),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_unmapped(reg_unmapped),
    .input_ctrl(input_ctrl), .out01_ctrl(out01_ctrl), .auto_inputs_ready(auto_inputs_ready));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // hang guard: the run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic hit(input logic [15:0] x);
    return x >= 16'h0004 && x <= 16'h0006;
  endfunction

  // register codes 00 and 01 share one driver kind
  function automatic logic [1:0] drv(input logic [1:0] c);
    return (c == 2'h3) ? 2'h2 : ((c == 2'h2) ? 2'h1 : 2'h0);
  endfunction

  // the host keeps reserved bits at zero; the model stores what it sends
  task automatic wr(input logic [15:0] x, input logic [15:0] d);
    logic [15:0] k;
    k = (x == 16'h0005) ? OUTPUT_PAIR0_CONTROL_WMASK
      : (x == 16'h0006) ? OUTPUT_PAIR0_DIVIDER_WMASK : 16'hffff;
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = x;
    reg_wdata = d & k;
    @(negedge mclk);
    reg_wr = 1'b0;
    if (serial_mode && hit(x)) begin
      m[x[2:0]] = d & k;
    end
  endtask

  // rvalid stands only in the cycle after the strobe, so it is looked at there
  task automatic rd(input logic [15:0] x);
    @(negedge mclk);
    reg_rd = 1'b1;
    reg_addr = x;
    @(negedge mclk);
    reg_rd = 1'b0;
    if (serial_mode) last = hit(x) ? m[x[2:0]] : 16'h0000;
    chk({31'h0, reg_rvalid}, {31'h0, serial_mode});
    chk({31'h0, reg_unmapped}, {31'h0, serial_mode & ~hit(x)});
    chk({16'h0, reg_rdata}, {16'h0, last});
  endtask

  task automatic chk_ctrl();
    logic [15:0] c;
    logic [15:0] o;
    logic [16:0] ei;
    logic [17:0] eo;
    c = m[4];
    o = m[5];
    ei = {c[14], c[15], c[13], c[13] & c[12] & ref_sel_pin, 5'(c[11:8]) + 5'h01,
          (c[4:3] == 2'h3) ? 2'h2 : c[4:3], c[2], c[0], c[7:6], c[5], c[1]};
    eo = {drv(o[4:3]), o[2:1], drv(o[8:7]), o[6:5], o[0], 9'(m[6][7:0]) + 9'h001};
    @(negedge mclk);
    chk({15'h0, input_ctrl}, {15'h0, ei});
    chk({14'h0, out01_ctrl}, {14'h0, eo});
    chk({31'h0, auto_inputs_ready}, {31'h0, ~c[13] & c[5] & c[2]});
  endtask

  task automatic do_reset();
    rst_n = 1'b0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    m[4] = 16'h0000;
    m[5] = 16'h0000;
    m[6] = 16'h0000;
    last = 16'h0000;
  endtask

  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    serial_mode = 1'b1;
    ref_sel_pin = 1'b1;
    do_reset();
    chk_ctrl();
    for (int i = 4; i <= 6; i++) rd(16'(i));
    // all four codes of every 2-bit field of every register; the dividers see only repeated patterns
    for (int k = 0; k < 4; k++) begin
      for (int i = 4; i <= 6; i++) begin
        wr(16'(i), {8{2'(k)}});
        chk_ctrl();
        rd(16'(i));
      end
    end
    // auto with the choice bit set, then manual, each with the pin both ways
    for (int k = 0; k < 4; k++) begin
      ref_sel_pin = k[0];
      wr(16'h0004, k[1] ? 16'h3024 : 16'h1024);
      chk_ctrl();
    end
    // random traffic, with the bank sometimes locked and unmapped indices
    for (int i = 0; i < 40; i++) begin
      a = 16'h0003 + 16'($unsigned($random(seed)) % 5);
      serial_mode = ($random(seed) % 4) != 0;
      ref_sel_pin = 1'($random(seed));
      wr(a, 16'($random(seed)));
      chk_ctrl();
      rd(a);
    end
    serial_mode = 1'b1;
    wr(16'h0005, 16'h01ff);
    do_reset();
    chk_ctrl();
    for (int i = 4; i <= 6; i++) rd(16'(i));
    stop_test();
  end
endmodule

// File: hdl/cfg_word.sv
/*
  One 16-bit configuration register with a fixed index, a write mask
  and a value after reset.
  It assumes the caller qualifies wr_en with the access mode.
*/
`timescale 1ns/1ps
module cfg_word
  import clkgen_cfg_pkg::*;
#(
  parameter logic [15:0] INDEX   = 16'h0000,
  parameter logic [15:0] WMASK   = 16'hffff,
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [REG_W-1:0]  wdata,
  output logic                   hit,
  output logic      [REG_W-1:0]  q
);

  logic [REG_W-1:0] word_r;

  assign hit = (addr == INDEX);
  assign q   = word_r;

  // keeps the last written value; reserved bits never store
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      word_r <= RST_VAL;
    end else if (wr_en && hit) begin
      word_r <= wdata & WMASK;
    end
  end

endmodule

// File: hdl/input_mux_out01_cfg.sv
/*
  Configuration bank for the reference smart multiplexer, the two input
  buffers and the driver, supply and shared divider of output channels
  0 and 1. Holds three registers and turns their fields into registered
  control levels for the analog blocks.
  Every control level leaves a flip-flop one edge after the stored
  word changes. Divider ratios are carried as field plus one so the
  analog side never decodes a zero. Reserved bits are not stored and
  read back as zero. The pin-programmed presets live elsewhere; here
  a low serial_mode only locks the bank.
  Assumes the serial front end hands over single-cycle register
  accesses synchronous to mclk, and that the reference-select pin is
  already synchronous to mclk.
*/
`timescale 1ns/1ps
module input_mux_out01_cfg
  import clkgen_cfg_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              serial_mode,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [REG_W-1:0]  reg_wdata,
  input  wire logic              ref_sel_pin,
  output logic      [REG_W-1:0]  reg_rdata,
  output logic                   reg_rvalid,
  output logic                   reg_unmapped,
  output input_ctrl_t            input_ctrl,
  output out01_ctrl_t            out01_ctrl,
  output logic                   auto_inputs_ready
);

  // access qualification
  logic             wr_ok;
  logic             rd_ok;
  logic             hit_in;
  logic             hit_ctl;
  logic             hit_div;
  logic [REG_W-1:0] in_q;
  logic [REG_W-1:0] ctl_q;
  logic [REG_W-1:0] div_q;

  // registered outputs, plus the decoded next values of the two control words
  logic [REG_W-1:0] rdata_r;
  logic             rvalid_r;
  logic             unmapped_r;
  input_ctrl_t      input_ctrl_r;
  input_ctrl_t      input_ctrl_nxt;
  out01_ctrl_t      out01_ctrl_r;
  out01_ctrl_t      out01_ctrl_nxt;
  logic             auto_ready_r;

  // helper terms shared by the processes below
  logic             any_hit;
  logic             any_access;
  logic             pin_secondary;
  logic             auto_ok;

  // fields of input_select_config
  logic [1:0] refmux_pulse_shape;
  logic       refmux_auto_manual;
  logic       refmux_manual_choice;
  logic [3:0] primary_input_divider;
  logic [1:0] secondary_buffer_type;
  logic       secondary_input_on;
  logic [1:0] primary_buffer_type;
  logic       primary_input_on;
  logic       secondary_rail_level;
  logic       primary_rail_level;

  // fields of output_pair0_control and output_pair0_divider
  logic [1:0] out1_driver_type;
  logic [1:0] out1_output_state;
  logic [1:0] out0_driver_type;
  logic [1:0] out0_output_state;
  logic       out01_rail_level;
  logic [7:0] out01_integer_divider;

  // pin-programmed mode locks the bank against serial traffic
  assign wr_ok = reg_wr && serial_mode;
  assign rd_ok = reg_rd && serial_mode;
  assign any_access = wr_ok || rd_ok;

  // the three registers
  cfg_word #(
    .INDEX   (INPUT_SELECT_CONFIG_IDX),
    .WMASK   (INPUT_SELECT_CONFIG_WMASK),
    .RST_VAL (INPUT_SELECT_CONFIG_RST)
  ) u_input_select_config (
    .mclk  (mclk),
    .rst_n (rst_n),
    .wr_en (wr_ok),
    .addr  (reg_addr),
    .wdata (reg_wdata),
    .hit   (hit_in),
    .q     (in_q)
  );

  cfg_word #(
    .INDEX   (OUTPUT_PAIR0_CONTROL_IDX),
    .WMASK   (OUTPUT_PAIR0_CONTROL_WMASK),
    .RST_VAL (OUTPUT_PAIR0_CONTROL_RST)
  ) u_output_pair0_control (
    .mclk  (mclk),
    .rst_n (rst_n),
    .wr_en (wr_ok),
    .addr  (reg_addr),
    .wdata (reg_wdata),
    .hit   (hit_ctl),
    .q     (ctl_q)
  );

  cfg_word #(
    .INDEX   (OUTPUT_PAIR0_DIVIDER_IDX),
    .WMASK   (OUTPUT_PAIR0_DIVIDER_WMASK),
    .RST_VAL (OUTPUT_PAIR0_DIVIDER_RST)
  ) u_output_pair0_divider (
    .mclk  (mclk),
    .rst_n (rst_n),
    .wr_en (wr_ok),
    .addr  (reg_addr),
    .wdata (reg_wdata),
    .hit   (hit_div),
    .q     (div_q)
  );

  // an index outside the three words answers as unmapped
  assign any_hit = hit_in || hit_ctl || hit_div;

  // field extraction from the stored words
  assign refmux_pulse_shape    = in_q[PULSE_SHAPE_LSB +: 2];
  assign refmux_auto_manual    = in_q[AUTO_MANUAL_BIT];
  assign refmux_manual_choice  = in_q[MANUAL_CHOICE_BIT];
  assign primary_input_divider = in_q[PRI_DIV_LSB +: 4];
  assign secondary_buffer_type = in_q[SEC_BUF_LSB +: 2];
  assign secondary_input_on    = in_q[SEC_ON_BIT];
  assign primary_buffer_type   = in_q[PRI_BUF_LSB +: 2];
  assign primary_input_on      = in_q[PRI_ON_BIT];
  assign secondary_rail_level  = in_q[SEC_RAIL_BIT];
  assign primary_rail_level    = in_q[PRI_RAIL_BIT];
  assign out1_driver_type      = ctl_q[OUT1_DRV_LSB +: 2];
  assign out1_output_state     = ctl_q[OUT1_STATE_LSB +: 2];
  assign out0_driver_type      = ctl_q[OUT0_DRV_LSB +: 2];
  assign out0_output_state     = ctl_q[OUT0_STATE_LSB +: 2];
  assign out01_rail_level      = ctl_q[OUT01_RAIL_BIT];
  assign out01_integer_divider = div_q[OUT01_DIV_LSB +: 8];

  // the secondary needs both the manual choice and the pin
  assign pin_secondary = refmux_manual_choice && ref_sel_pin;

  // both buffers powered while the mux is in auto mode
  assign auto_ok = !refmux_auto_manual && primary_input_on && secondary_input_on;

  // driver code to driver kind; both low codes mean LVDS
  // the internal kind codes are packed, not the register codes
  function automatic driver_kind_t drv_decode(input logic [1:0] code);
    driver_kind_t kind;
    kind = DRV_LVDS;
    unique case (code)
      2'h0, 2'h1: kind = DRV_LVDS;
      2'h2:       kind = DRV_CML;
      2'h3:       kind = DRV_PECL;
    endcase
    return kind;
  endfunction

  // reference path decode
  // decoded once here so both analog controls switch on one edge
  always_comb begin
    input_ctrl_nxt = '0;
    // bit 1 of the code reshapes, bit 0 delays
    unique case (pulse_shape_t'(refmux_pulse_shape))
      SHAPE_NONE: begin
        input_ctrl_nxt.delay_on   = 1'b0;
        input_ctrl_nxt.reshape_on = 1'b0;
      end
      SHAPE_DELAY: begin
        input_ctrl_nxt.delay_on   = 1'b1;
        input_ctrl_nxt.reshape_on = 1'b0;
      end
      SHAPE_RESHAPE: begin
        input_ctrl_nxt.delay_on   = 1'b0;
        input_ctrl_nxt.reshape_on = 1'b1;
      end
      SHAPE_BOTH: begin
        input_ctrl_nxt.delay_on   = 1'b1;
        input_ctrl_nxt.reshape_on = 1'b1;
      end
    endcase
    input_ctrl_nxt.manual_mode = refmux_auto_manual;
    // auto mode owns the choice, so the manual bit is masked off there
    if (refmux_auto_manual) begin
      input_ctrl_nxt.use_secondary = pin_secondary;
    end else begin
      input_ctrl_nxt.use_secondary = 1'b0;
    end
    input_ctrl_nxt.primary_divide_ratio = {1'b0, primary_input_divider} + 5'h01;
    input_ctrl_nxt.secondary_buffer_type = buffer_kind_t'(secondary_buffer_type);
    input_ctrl_nxt.secondary_input_on    = secondary_input_on;
    // the primary buffer has no crystal mode: 11 aliases onto LVCMOS
    if (primary_buffer_type == 2'h3) begin
      input_ctrl_nxt.primary_buffer_type = BUF_LVCMOS;
    end else begin
      input_ctrl_nxt.primary_buffer_type = buffer_kind_t'(primary_buffer_type);
    end
    input_ctrl_nxt.primary_input_on     = primary_input_on;
    input_ctrl_nxt.primary_rail_level   = primary_rail_level;
    input_ctrl_nxt.secondary_rail_level = secondary_rail_level;
  end

  // output pair decode
  // channels 0 and 1 share the rail bit and the divider
  always_comb begin
    out01_ctrl_nxt = '0;
    out01_ctrl_nxt.out0.driver_type  = drv_decode(out0_driver_type);
    out01_ctrl_nxt.out1.driver_type  = drv_decode(out1_driver_type);
    out01_ctrl_nxt.out0.output_state = output_state_t'(out0_output_state);
    out01_ctrl_nxt.out1.output_state = output_state_t'(out1_output_state);
    // one rail bit for both channels; reset code is 1.8 V
    out01_ctrl_nxt.rail_level = out01_rail_level;
    out01_ctrl_nxt.divide_ratio = {1'b0, out01_integer_divider} + 9'h001;
  end

  // reference controls are registered so the analog side sees no glitch
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      input_ctrl_r <= '0;
      // a zero field means divide-by-1, so the carried ratio is one
      input_ctrl_r.primary_divide_ratio <= 5'h01;
    end else begin
      input_ctrl_r <= input_ctrl_nxt;
    end
  end

  // output pair controls
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      out01_ctrl_r <= '0;
      // same reasoning as the primary ratio: zero field is divide-by-1
      out01_ctrl_r.divide_ratio <= 9'h001;
    end else begin
      out01_ctrl_r <= out01_ctrl_nxt;
    end
  end

  // auto selection is only safe with both buffers powered; the host
  // must arrange that, this flag just reports it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      auto_ready_r <= 1'b0;
    end else begin
      auto_ready_r <= auto_ok;
    end
  end

  // read path: one cycle after the request, reserved bits as zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_r    <= 16'h0000;
      rvalid_r   <= 1'b0;
      unmapped_r <= 1'b0;
    end else begin
      rvalid_r   <= rd_ok;
      unmapped_r <= any_access && !any_hit;
      // a read beside a write returns the old word, since q is the stored value
      if (rd_ok) begin
        unique case (1'b1)
          hit_in:  rdata_r <= in_q;
          hit_ctl: rdata_r <= ctl_q;
          hit_div: rdata_r <= div_q;
          default: rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  assign reg_rdata         = rdata_r;
  assign reg_rvalid        = rvalid_r;
  assign reg_unmapped      = unmapped_r;
  assign input_ctrl        = input_ctrl_r;
  assign out01_ctrl        = out01_ctrl_r;
  assign auto_inputs_ready = auto_ready_r;

endmodule

// File: inc/clkgen_cfg_pkg.sv
/*
  Package for the input-mux and output-pair-0/1 configuration bank.
  It holds the register indices, field positions, reset values, field
  encodings and the packed carriers that leave the bank.
  It assumes a serial front end that delivers 16-bit register accesses
  already decoded to a register index.
*/
package clkgen_cfg_pkg;

  // register access geometry
  localparam int unsigned REG_W  = 16;
  localparam int unsigned ADDR_W = 16;

  // register indices as printed
  localparam logic [15:0] INPUT_SELECT_CONFIG_IDX  = 16'h0004;
  localparam logic [15:0] OUTPUT_PAIR0_CONTROL_IDX = 16'h0005;
  localparam logic [15:0] OUTPUT_PAIR0_DIVIDER_IDX = 16'h0006;

  // input_select_config field positions
  localparam int unsigned PULSE_SHAPE_LSB   = 14;
  localparam int unsigned AUTO_MANUAL_BIT   = 13;
  localparam int unsigned MANUAL_CHOICE_BIT = 12;
  localparam int unsigned PRI_DIV_LSB       = 8;
  localparam int unsigned SEC_BUF_LSB       = 6;
  localparam int unsigned SEC_ON_BIT        = 5;
  localparam int unsigned PRI_BUF_LSB       = 3;
  localparam int unsigned PRI_ON_BIT        = 2;
  localparam int unsigned SEC_RAIL_BIT      = 1;
  localparam int unsigned PRI_RAIL_BIT      = 0;

  // output_pair0_control field positions
  localparam int unsigned OUT1_DRV_LSB   = 7;
  localparam int unsigned OUT1_STATE_LSB = 5;
  localparam int unsigned OUT0_DRV_LSB   = 3;
  localparam int unsigned OUT0_STATE_LSB = 1;
  localparam int unsigned OUT01_RAIL_BIT = 0;

  // output_pair0_divider field position
  localparam int unsigned OUT01_DIV_LSB = 0;

  // writable bits; reserved bits are dropped and read back as zero
  localparam logic [15:0] INPUT_SELECT_CONFIG_WMASK  = 16'hffff;
  localparam logic [15:0] OUTPUT_PAIR0_CONTROL_WMASK = 16'h01ff;
  localparam logic [15:0] OUTPUT_PAIR0_DIVIDER_WMASK = 16'h00ff;

  // values after reset: pulse shape 00, supplies at the 1.8 V code
  localparam logic [15:0] INPUT_SELECT_CONFIG_RST  = 16'h0000;
  localparam logic [15:0] OUTPUT_PAIR0_CONTROL_RST = 16'h0000;
  localparam logic [15:0] OUTPUT_PAIR0_DIVIDER_RST = 16'h0000;

  // encodings
  typedef enum logic [1:0] {
    SHAPE_NONE    = 2'h0,
    SHAPE_DELAY   = 2'h1,
    SHAPE_RESHAPE = 2'h2,
    SHAPE_BOTH    = 2'h3
  } pulse_shape_t;

  typedef enum logic [1:0] {
    BUF_CML    = 2'h0,
    BUF_LVDS   = 2'h1,
    BUF_LVCMOS = 2'h2,
    BUF_XTAL   = 2'h3
  } buffer_kind_t;

  typedef enum logic [1:0] {
    DRV_LVDS = 2'h0,
    DRV_CML  = 2'h1,
    DRV_PECL = 2'h2
  } driver_kind_t;

  typedef enum logic [1:0] {
    OUT_OFF     = 2'h0,
    OUT_CLOCK   = 2'h1,
    OUT_STATIC0 = 2'h2,
    OUT_STATIC1 = 2'h3
  } output_state_t;

  // rail level code: 0 is 1.8 V, 1 is 2.5/3.3 V
  localparam logic RAIL_1V8 = 1'b0;

  // controls towards the reference path
  typedef struct packed {
    logic         delay_on;
    logic         reshape_on;
    logic         manual_mode;
    logic         use_secondary;
    logic [4:0]   primary_divide_ratio;
    buffer_kind_t primary_buffer_type;
    logic         primary_input_on;
    logic         primary_rail_level;
    buffer_kind_t secondary_buffer_type;
    logic         secondary_input_on;
    logic         secondary_rail_level;
  } input_ctrl_t;

  // controls towards one output driver
  typedef struct packed {
    driver_kind_t  driver_type;
    output_state_t output_state;
  } out_ctrl_t;

  // controls shared by output channels 0 and 1
  typedef struct packed {
    out_ctrl_t  out0;
    out_ctrl_t  out1;
    logic       rail_level;
    logic [8:0] divide_ratio;
  } out01_ctrl_t;

endpackage
